// ==== hdl/idr_cmd_if.sv ====
`timescale 1ns/1ns
interface idr_cmd_if;
	logic        exec;
	logic [23:0] word;
	modport src (output exec, output word);
	modport dst (input exec, input word);
endinterface : idr_cmd_if

// ==== hdl/idr_i2c_slave.sv ====
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module idr_i2c_slave
	import idr_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic [6:0] own_addr,
	input  wire logic [7:0] rd_data,
	idr_cmd_if.src          cmd,
	output logic            high_speed_protocol,
	output logic            busy
);
	typedef enum logic [2:0] {
		IDR_IDLE = 3'b000, IDR_ADDR = 3'b001, IDR_WR = 3'b011,
		IDR_ACK  = 3'b010, IDR_RD   = 3'b110, IDR_RACK = 3'b111
	} idr_st_e;

	// =====================================================================
	// two-flop sync, then edge detect on the second stage only
	logic [1:0] scl_s_r, sda_s_r;
	logic       scl_d_r, sda_d_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_s_r <= 2'b11;
			sda_s_r <= 2'b11;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_in};
			sda_s_r <= {sda_s_r[0], sda_in};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end
	wire scl   = scl_s_r[1];
	wire sda   = sda_s_r[1];
	wire rise  = scl && !scl_d_r;
	wire fall  = !scl && scl_d_r;
	wire start = scl && scl_d_r && sda_d_r && !sda;
	wire stop  = scl && scl_d_r && !sda_d_r && sda;

	// =====================================================================
	idr_st_e    st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [1:0] byte_r;
	logic [23:0] word_r;
	logic       ack_r, drv_r, exec_r, hs_r, first_r, rw_r;
	wire        byte_done = rise && bit_r == 4'd7;
	wire [7:0]  cur  = {sh_r[6:0], sda};
	wire        hit  = cur[7:1] == own_addr; // no general call/10-bit
	wire        hsc  = cur[7:3] == IDR_HS_CODE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= IDR_IDLE; bit_r <= 4'd0; sh_r <= 8'h00; byte_r <= 2'd0;
			word_r <= 24'h00_0000; ack_r <= 1'b0; drv_r <= 1'b0;
			exec_r <= 1'b0; hs_r <= 1'b0; first_r <= 1'b0; rw_r <= 1'b0;
		end else begin
			exec_r <= 1'b0;
			if (stop) begin
				st_r <= IDR_IDLE;
				hs_r <= 1'b0;
				drv_r <= 1'b0;
			end else if (start) begin
				st_r <= IDR_ADDR; bit_r <= 4'd0; drv_r <= 1'b0;
				first_r <= 1'b1;
			end else unique case (st_r)
			IDR_IDLE: ;
			IDR_ADDR, IDR_WR: if (rise) begin
				sh_r  <= cur;
				bit_r <= bit_r + 4'd1;
				if (byte_done) begin
					bit_r <= 4'd0;
					if (st_r == IDR_ADDR) begin
						if (hsc) begin
							hs_r <= 1'b1; // no ack
							st_r <= IDR_IDLE;
						end else begin
							ack_r <= hit;
							rw_r  <= cur[0];
							byte_r <= 2'd0;
							st_r  <= hit ? IDR_ACK : IDR_IDLE;
						end
					end else begin
						// command byte is kept for later data pairs
						word_r <= (byte_r == 2'd0) ? {cur, word_r[15:0]}
							: {word_r[23:16], word_r[7:0], cur};
						ack_r  <= 1'b1;
						st_r   <= IDR_ACK;
					end
				end
			end
			IDR_ACK: begin
				if (fall && !drv_r) drv_r <= 1'b1; // ack in 9th
				else if (fall && drv_r) begin
					drv_r <= 1'b0;
					if (!first_r && byte_r == 2'd2) begin
						exec_r <= 1'b1;
						byte_r <= 2'd1; // later updates need two bytes
					end else if (!first_r) byte_r <= byte_r + 2'd1;
					if (first_r && rw_r) begin
						st_r <= IDR_RD;
						sh_r <= rd_data;
						drv_r <= !rd_data[7];
					end else st_r <= IDR_WR;
					first_r <= 1'b0;
				end
			end
			IDR_RD: if (fall) begin
				bit_r <= bit_r + 4'd1;
				if (bit_r == 4'd7) begin
					drv_r <= 1'b0; bit_r <= 4'd0; st_r <= IDR_RACK;
				end else begin
					sh_r  <= {sh_r[6:0], 1'b0};
					drv_r <= !sh_r[6];
				end
			end
			IDR_RACK: if (rise) begin
				// nack from master ends the read; ack sends another byte
				st_r <= sda ? IDR_IDLE : IDR_RACK;
				if (!sda) begin
					sh_r <= rd_data; bit_r <= 4'd0;
				end
			end else if (fall && !sda_d_r && bit_r == 4'd0) begin
				st_r <= IDR_RD; drv_r <= !sh_r[7];
			end
			default: st_r <= IDR_IDLE;
			endcase
		end
	end
	wire unused_ack = ack_r;

	// open-drain: only ever pull low; slave never drives clock
	assign sda_out  = 1'b0;
	assign sda_oe   = drv_r;
	assign scl_out  = 1'b0;
	assign scl_oe   = 1'b0;
	assign cmd.exec = exec_r;
	assign cmd.word = word_r;
	assign high_speed_protocol  = hs_r;
	assign busy     = st_r != IDR_IDLE;
endmodule : idr_i2c_slave

// ==== hdl/idr_pkg.sv ====
package idr_pkg;
	// =====================================================================
	// bus map (byte addresses)
	localparam logic [7:0]  IDR_CTRL_OFS      = 8'h00;
	localparam logic [7:0]  IDR_STAT_OFS      = 8'h04;
	localparam logic [7:0]  IDR_LAST_OFS      = 8'h08;
	localparam logic [7:0]  IDR_RDAT_OFS      = 8'h0C;
	// =====================================================================
	// ctrl fields
	localparam int          IDR_CTRL_ADDR_LSB = 0;
	localparam int          IDR_CTRL_CHAN_LSB = 8;
	localparam logic [31:0] IDR_CTRL_RST      = 32'h0000_0048;
	localparam logic [31:0] IDR_RDAT_RST      = 32'h0000_0000;
	// =====================================================================
	// two-wire protocol
	localparam logic [3:0]  IDR_CMD_FLEX      = 4'h9;
	localparam logic [3:0]  IDR_CMD_STATIC    = 4'h8;
	localparam int          IDR_FLEX_SEL_POS  = 14;
	localparam int          IDR_FLEX_HI_POS   = 13;
	localparam int          IDR_FLEX_LO_POS   = 12;
	localparam int          IDR_STATIC_ON_POS = 4;
	localparam logic [4:0]  IDR_HS_CODE       = 5'h01;
	localparam logic [1:0]  IDR_REF_OFF       = 2'h0;
	localparam logic [1:0]  IDR_REF_FOLLOW    = 2'h1;
	localparam logic [1:0]  IDR_REF_ALWAYS    = 2'h2;
	localparam logic [1:0]  IDR_REF_STATIC_ON = 2'h3;
endpackage : idr_pkg

// ==== hdl/idr_ref_ctl.sv ====
`timescale 1ns/1ns
module idr_ref_ctl
	import idr_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	idr_cmd_if.dst          cmd,
	input  wire logic [7:0] chan_up,
	output logic            flex_mode,
	output logic [1:0]      ref_setting,
	output logic            ref_power_en
);
	logic       flex_r;
	logic [1:0] set_r;
	wire  [3:0] code    = cmd.word[23:20];
	wire        sel     = cmd.word[IDR_FLEX_SEL_POS];
	wire  [1:0] fset    = {cmd.word[IDR_FLEX_HI_POS], cmd.word[IDR_FLEX_LO_POS]};
	wire        st_on   = cmd.word[IDR_STATIC_ON_POS];
	wire        is_flex = cmd.exec && code == IDR_CMD_FLEX;
	wire        is_stat = cmd.exec && code == IDR_CMD_STATIC && !flex_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flex_r <= 1'b0;
			set_r  <= IDR_REF_OFF;
		end else if (is_flex && !sel) begin
			flex_r <= 1'b0;
			set_r  <= IDR_REF_OFF;
		end else if (is_flex && fset == 2'b00) begin
			flex_r <= 1'b1;
			set_r  <= IDR_REF_FOLLOW;
		end else if (is_flex && fset == 2'b01) begin
			flex_r <= 1'b1;
			set_r  <= IDR_REF_ALWAYS;
		end else if (is_flex && fset == 2'b10 && !st_on) begin
			flex_r <= 1'b1;
			set_r  <= IDR_REF_OFF;
		end else if (is_stat) begin
			set_r  <= st_on ? IDR_REF_STATIC_ON : IDR_REF_OFF;
		end
	end

	assign flex_mode   = flex_r;
	assign ref_setting = set_r;
	// always-on ignores channel power-down; follow and static-on follow channels; off never enables
	assign ref_power_en = (set_r == IDR_REF_ALWAYS)
		|| ((set_r == IDR_REF_FOLLOW || set_r == IDR_REF_STATIC_ON)
		&& |chan_up);
endmodule : idr_ref_ctl

// ==== hdl/idr_top.sv ====
`timescale 1ns/1ns
module idr_top
	import idr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             ref_power_en
);
	// =====================================================================
	// bus slave: single-cycle data phase
	logic        wr_r;
	logic [7:0]  ad_r;
	logic [31:0] ctrl_r, rdat_r, last_r;
	wire         take = hsel && hready && htrans[1];
	wire         unused = |{hsize, haddr[31:8]};

	idr_cmd_if   cmd ();
	logic        flex, hs, busy;
	logic [1:0]  rset;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			ad_r <= 8'h00;
		end else begin
			wr_r <= take && hwrite;
			ad_r <= take ? haddr[7:0] : ad_r;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= IDR_CTRL_RST;
			rdat_r <= IDR_RDAT_RST;
			last_r <= 32'h0000_0000;
		end else begin
			if (wr_r && ad_r == IDR_CTRL_OFS) ctrl_r <= hwdata;
			if (wr_r && ad_r == IDR_RDAT_OFS) rdat_r <= hwdata;
			if (cmd.exec) last_r <= {8'h00, cmd.word};
		end
	end
	wire [31:0] stat = {26'h000_0000, busy, hs, ref_power_en, rset, flex};
	assign hrdata = (ad_r == IDR_CTRL_OFS) ? ctrl_r :
		(ad_r == IDR_STAT_OFS) ? stat :
		(ad_r == IDR_LAST_OFS) ? last_r :
		(ad_r == IDR_RDAT_OFS) ? rdat_r : 32'h0000_0000;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// =====================================================================
	idr_i2c_slave u_link (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.scl_out  (scl_out),
		.scl_oe   (scl_oe),
		.own_addr (ctrl_r[IDR_CTRL_ADDR_LSB +: 7]),
		.rd_data  (rdat_r[7:0]),
		.cmd      (cmd),
		.high_speed_protocol  (hs),
		.busy     (busy)
	);
	idr_ref_ctl u_ref (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.cmd          (cmd),
		.chan_up      (ctrl_r[IDR_CTRL_CHAN_LSB +: 8]),
		.flex_mode    (flex),
		.ref_setting  (rset),
		.ref_power_en (ref_power_en)
	);
endmodule : idr_top

// ==== tb/idr_checker.sv ====
`timescale 1ns/1ns
module idr_checker (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       scl_in,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       ref_power_en
);
	// ====================
	// helpers
	logic wr_dp_r;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_dp_r <= 1'b0;
		else
			wr_dp_r <= hsel && hready && htrans[1] && hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====================
	// properties
	property p_ready; hreadyout && !hresp; endproperty
	property p_no_scl; !scl_oe; endproperty
	property p_open_drain; sda_oe |-> !sda_out; endproperty
	// sync lag is under one low phase at the bench link rate
	property p_sda_hi; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
	property p_oe_min; $rose(sda_oe) |-> sda_oe [*6]; endproperty
	property p_oe_max; $rose(sda_oe) |-> ##[1:80] !sda_oe; endproperty
	property p_ref_cause;
		$changed(ref_power_en) |-> $past(wr_dp_r) || !scl_in || !$past(scl_in);
	endproperty
	property p_rst_ref;
		$rose(hresetn) |-> !ref_power_en ##1 !ref_power_en;
	endproperty
	a_ready: assert property (p_ready)
		else $error("bus answer not ready or not okay");
	a_no_scl: assert property (p_no_scl)
		else $error("slave drove the clock line");
	a_open_drain: assert property (p_open_drain)
		else $error("data line driven high");
	a_sda_hi: assert property (p_sda_hi)
		else $error("data drive changed while clock high");
	a_oe_min: assert property (p_oe_min)
		else $error("data pull shorter than a bit");
	a_oe_max: assert property (p_oe_max)
		else $error("data line never released");
	a_ref_cause: assert property (p_ref_cause)
		else $error("reference enable moved without cause");
	a_rst_ref: assert property (p_rst_ref)
		else $error("reference on after reset");
	c_ref_on: cover property ($rose(ref_power_en));
	c_ack: cover property ($rose(sda_oe));
	c_wr: cover property (wr_dp_r);
endmodule : idr_checker

bind idr_top idr_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .ref_power_en(ref_power_en));

// ==== tb/idr_i2c_master.sv ====
`timescale 1ns/1ns
module idr_i2c_master (
	output logic      scl_pull,
	output logic      sda_pull,
	input  wire logic sda
);
	// ====================
	// two-wire master, 800 ns bit, pulls only, never drives high
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// s is high if the line was high at either of the two samples in the high phase
	task automatic clk9(output logic s);
		#200 scl_pull = 1'b0;
		#100 s = sda;
		#200 s = s | sda;
		#100 scl_pull = 1'b1;
		#200;
	endtask : clk9
	task automatic start;
		// keep pin changes off the sampling edge
		#20;
		sda_pull = 1'b1;
		#400 scl_pull = 1'b1;
		#200;
	endtask : start
	task automatic stop;
		#20;
		sda_pull = 1'b1;
		#200 scl_pull = 1'b0;
		#400 sda_pull = 1'b0;
		#400;
	endtask : stop
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !b[i];
			clk9(s);
		end
		sda_pull = 1'b0;
		clk9(s);
		ack = !s;
	endtask : wbyte
	task automatic rbyte(input logic mack, output logic [7:0] b);
		logic s;
		sda_pull = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clk9(s);
			b[i] = s;
		end
		sda_pull = mack;
		clk9(s);
		sda_pull = 1'b0;
	endtask : rbyte
endmodule : idr_i2c_master

// ==== tb/idr_tb_top.sv ====
`timescale 1ns/1ns
module idr_tb_top;
	import idr_pkg::*;
	// ====================
	// signals
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ack;
	logic        scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
	logic        ref_power_en;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  rb;
	logic [31:0] haddr, hwdata, hrdata, rv;
	int          errors, checks;
	wire logic   scl_w = !(scl_pull || (scl_oe && !scl_out));
	wire logic   sda_w = !(sda_pull || (sda_oe && !sda_out));
	idr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.ref_power_en(ref_power_en));
	idr_i2c_master m (.scl_pull(scl_pull), .sda_pull(sda_pull), .sda(sda_w));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// about 3600 cycles of traffic, so 30000 leaves ample margin
	initial begin
		#3_000_000;
		errors++;
		report_and_stop();
	end
	// ====================
	// helpers
	task automatic report_and_stop;
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : ahb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
		ahb(1'b0, a, 32'h0000_0000);
		chk(n, rv, e);
	endtask : rd
	task automatic st(input logic [4:0] e);
		ahb(1'b0, IDR_STAT_OFS, 32'h0000_0000);
		chk("status", 32'(rv[5:0]), 32'({1'b0, e}));
		chk("ref_power_en", 32'(ref_power_en), 32'(e[3]));
	endtask : st
	task automatic chan(input logic [7:0] c);
		ahb(1'b1, IDR_CTRL_OFS, {16'h0000, c, 8'h48});
	endtask : chan
	task automatic xfer(input logic [6:0] ad, input logic [23:0] w, input logic e);
		m.start();
		m.wbyte({ad, 1'b0}, ack);
		chk("addr ack", 32'(ack), 32'(e));
		for (int i = 2; i >= 0 && e; i--) begin
			m.wbyte(w[8*i+:8], ack);
			chk("data ack", 32'(ack), 32'h0000_0001);
		end
		m.stop();
		repeat (4) @(posedge hclk);
	endtask : xfer
	// ====================
	// scenarios
	task automatic t_follow;
		chan(8'h00);
		xfer(7'h48, 24'h90_4000, 1'b1);
		st(5'h03);
		rd(IDR_LAST_OFS, 32'h0090_4000, "last word");
		chan(8'h04);
		st(5'h0B);
		chan(8'h00);
		st(5'h03);
	endtask : t_follow
	task automatic t_always;
		xfer(7'h48, 24'h95_5000, 1'b1);
		st(5'h0D);
		xfer(7'h48, 24'h80_0000, 1'b1);
		st(5'h0D);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		st(5'h00);
	endtask : t_always
	task automatic t_off;
		chan(8'hFF);
		xfer(7'h48, 24'h90_4000, 1'b1);
		st(5'h0B);
		xfer(7'h48, 24'h90_6000, 1'b1);
		st(5'h01);
	endtask : t_off
	task automatic t_static;
		xfer(7'h48, 24'h90_3000, 1'b1);
		rd(IDR_STAT_OFS, 32'h0000_0000, "flex flag");
		chan(8'h00);
		xfer(7'h48, 24'h80_0010, 1'b1);
		st(5'h06);
		chan(8'h01);
		st(5'h0E);
		xfer(7'h48, 24'h80_00EF, 1'b1);
		st(5'h00);
	endtask : t_static
	task automatic t_addr;
		logic [6:0] bad [3] = '{7'h49, 7'h00, 7'h78};
		for (int i = 0; i < 3; i++)
			xfer(bad[i], 24'h90_5000, 1'b0);
		st(5'h00);
	endtask : t_addr
	task automatic t_hs;
		m.start();
		m.wbyte(8'h09, ack);
		chk("master code ack", 32'(ack), 32'h0000_0000);
		st(5'h10);
		m.stop();
		st(5'h00);
	endtask : t_hs
	task automatic t_pair;
		logic [39:0] b = 40'h90_4000_5000;
		m.start();
		m.wbyte({7'h48, 1'b0}, ack);
		chk("pair addr ack", 32'(ack), 32'h0000_0001);
		for (int i = 4; i >= 0; i--) begin
			m.wbyte(b[8*i+:8], ack);
			chk("pair data ack", 32'(ack), 32'h0000_0001);
		end
		m.stop();
		repeat (4) @(posedge hclk);
		rd(IDR_LAST_OFS, 32'h0090_5000, "pair word");
		st(5'h0D);
	endtask : t_pair
	task automatic t_read;
		ahb(1'b1, IDR_RDAT_OFS, 32'h0000_00A5);
		m.start();
		m.wbyte({7'h48, 1'b1}, ack);
		chk("read addr ack", 32'(ack), 32'h0000_0001);
		// clock held low while the status shows the link busy
		rd(IDR_STAT_OFS, 32'h0000_002D, "busy");
		#20;
		m.rbyte(1'b1, rb);
		chk("read byte", 32'(rb), 32'h0000_00A5);
		m.rbyte(1'b0, rb);
		chk("read again", 32'(rb), 32'h0000_00A5);
		m.stop();
	endtask : t_read
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		errors = 0;
		checks = 0;
		hsize = 3'b010;
		hresetn = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd(IDR_CTRL_OFS, IDR_CTRL_RST, "ctrl reset");
		rd(IDR_RDAT_OFS, IDR_RDAT_RST, "rdat reset");
		rd(8'h10, 32'h0000_0000, "unmapped");
		st(5'h00);
		t_follow();
		t_always();
		t_off();
		t_static();
		t_addr();
		t_hs();
		t_pair();
		t_read();
		report_and_stop();
	end
endmodule : idr_tb_top
